// ===== inc/fel_consts.svh
// Constants for the fault escalation and lockup unit
`ifndef FEL_CONSTS_SVH
`define FEL_CONSTS_SVH
`define FEL_ADDR_W 4
`define FEL_REG_HFS 4'h0
`define FEL_REG_CFS 4'h1
`define FEL_REG_PFA 4'h2
`define FEL_REG_BFA 4'h3
`define FEL_REG_CTL 4'h4
`define FEL_REG_PRI 4'h5
`define FEL_REG_IST 4'h6
`define FEL_REG_IMSK 4'h7
`define FEL_REG_STAT 4'h8
`define FEL_HF_VECT 1
`define FEL_HF_ESC 30
`define FEL_PRI_W 8
`define FEL_PRI_HARD 8'hFF
`define FEL_PRI_NMI 8'hFE
`endif

// ===== inc/fel_pkg.sv
// Types of the fault escalation and lockup unit
package fel_pkg;
  typedef enum logic [1:0] {
    FEL_RUN = 2'b00,
    FEL_LOCK = 2'b01
  } fel_state_t;
  typedef enum logic [2:0] {
    FEL_X_NONE = 3'd0,
    FEL_X_HARD = 3'd1,
    FEL_X_PROT = 3'd2,
    FEL_X_BUS = 3'd3,
    FEL_X_USAGE = 3'd4
  } fel_exc_t;
endpackage

// ===== logic/fel_unit.sv
// Fault classification, escalation and lockup unit
// Behaviour
// - Vector read bus error gives hard fault
// - Escalation sets escalated fault flag
// - Protection mismatch flags by access kind
// - No-execute fetch flags even unit off
// - Bus errors flagged by kind
// - Six usage fault causes, own flags
// - Bad state covers continuation return
// - Configurable priorities, hard fault fixed
// - Class enables steer handler choice
// - Same class fault escalates to hard
// - Priority not above current escalates
// - Disabled class handler escalates
// - Stacking bus fault into bus handler kept
// - Hard fault preempts all but reset, NMI
// - Capture protection and bus fault address
// - Hard fault in NMI/hard enters lockup
// - Leave lockup on reset, NMI, halt
// - NMI cannot release NMI-origin lockup
//
// The register offsets and the strobed register port were left to the implementer.
`include "fel_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module fel_unit
  import fel_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`FEL_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [4:0] prot_err,
  input wire logic no_execute_region,
  input wire logic [31:0] prot_addr,
  input wire logic [5:0] bus_err,
  input wire logic vector_bus_err,
  input wire logic [31:0] bus_addr,
  input wire logic [5:0] usage_err,
  input wire logic [7:0] cur_pri,
  input wire logic in_handler,
  input wire logic [2:0] active_class,
  input wire logic nmi_active,
  input wire logic nmi_req,
  input wire logic debug_halt,
  output logic [2:0] take_exc,
  output logic take_valid,
  output logic lockup,
  output logic irq
);
  // prot_err: 0 instr,1 data,2 stack,3 unstack,4 lazy fp
  // bus_err: 0 stack,1 unstack,2 prefetch,3 lazy fp,4 exact,5 inexact
  // usage_err: 0 cop,1 undef,2 bad state,3 bad return,4 unaligned,5 div0
  typedef struct packed {
    logic [31:0] hfs;
    logic [31:0] cfs;
    logic [31:0] pfa;
    logic [31:0] bfa;
    logic [2:0] en;
    logic [23:0] pri;
    logic [2:0] ist;
    logic [2:0] imsk;
    logic [31:0] rdata;
    logic [2:0] take;
    logic tv;
    fel_state_t st;
    logic lock_nmi;
    logic lock;
    logic irq;
  } fel_regs_t;

  fel_regs_t r_q;
  fel_regs_t r_d;

  logic [4:0] prot_ev;
  logic [5:0] bus_ev;
  logic [7:0] prot_byte;
  logic [7:0] bus_byte;
  logic [15:0] use_half;
  logic [2:0] cls;
  logic [7:0] cls_pri;
  logic cls_en;
  logic escalate;
  logic hard;
  logic hard_from_nmi;
  logic wr_hfs;
  logic wr_cfs;

  always_comb begin
    prot_ev = prot_err;
    prot_ev[0] = prot_err[0] | no_execute_region;
    bus_ev = bus_err;
    prot_byte = {1'b0, 1'b0, prot_ev[4], prot_ev[3], prot_ev[2], 1'b0, prot_ev[1:0]};
    bus_byte = {1'b0, 1'b0, bus_ev[3], bus_ev[0], bus_ev[1], bus_ev[5], bus_ev[4], bus_ev[2]};
    // Bit 1 of usage holds the bad state cause, fed by core decode
    use_half = {6'h00, usage_err[5], usage_err[4], 4'h0,
                usage_err[0], usage_err[3], usage_err[2], usage_err[1]};
    // Lowest numbered class wins when several report together
    cls = FEL_X_NONE;
    if (|usage_err) begin
      cls = FEL_X_USAGE;
    end
    if (|bus_ev) begin
      cls = FEL_X_BUS;
    end
    if (|prot_ev) begin
      cls = FEL_X_PROT;
    end
    cls_pri = `FEL_PRI_HARD;
    cls_en = 1'b0;
    case (cls)
      FEL_X_PROT: begin
        cls_pri = r_q.pri[7:0];
        cls_en = r_q.en[0];
      end
      FEL_X_BUS: begin
        cls_pri = r_q.pri[15:8];
        cls_en = r_q.en[1];
      end
      FEL_X_USAGE: begin
        cls_pri = r_q.pri[23:16];
        cls_en = r_q.en[2];
      end
      default: begin
        cls_pri = `FEL_PRI_HARD;
        cls_en = 1'b0;
      end
    endcase
    escalate = 1'b0;
    if (cls != FEL_X_NONE) begin
      if (!cls_en) begin
        escalate = 1'b1;
      end else if (in_handler && active_class == cls) begin
        escalate = 1'b1;
      end else if (in_handler && cls_pri >= cur_pri) begin
        escalate = 1'b1;
      end
      // Corrupt stack during bus handler entry still runs the handler
      if (cls == FEL_X_BUS && bus_ev[0] && active_class == FEL_X_BUS && cls_en) begin
        escalate = 1'b0;
      end
    end
    hard = vector_bus_err | escalate;
    hard_from_nmi = nmi_active;
    wr_hfs = reg_wr && reg_addr == `FEL_REG_HFS;
    wr_cfs = reg_wr && reg_addr == `FEL_REG_CFS;

    r_d = r_q;
    r_d.tv = 1'b0;
    r_d.take = FEL_X_NONE;
    // Write-one-to-clear first so a same-cycle event wins
    if (wr_hfs) begin
      r_d.hfs = r_q.hfs & ~reg_wdata;
    end
    if (wr_cfs) begin
      r_d.cfs = r_q.cfs & ~reg_wdata;
    end
    if (reg_wr && reg_addr == `FEL_REG_CTL) begin
      r_d.en = reg_wdata[2:0];
    end
    if (reg_wr && reg_addr == `FEL_REG_PRI) begin
      r_d.pri = reg_wdata[23:0];
    end
    if (reg_wr && reg_addr == `FEL_REG_IST) begin
      r_d.ist = r_q.ist & ~reg_wdata[2:0];
    end
    if (reg_wr && reg_addr == `FEL_REG_IMSK) begin
      r_d.imsk = reg_wdata[2:0];
    end
    r_d.cfs[7:0] = r_d.cfs[7:0] | prot_byte;
    r_d.cfs[15:8] = r_d.cfs[15:8] | bus_byte;
    r_d.cfs[31:16] = r_d.cfs[31:16] | use_half;
    if (|prot_ev) begin
      r_d.pfa = prot_addr;
      r_d.cfs[7] = 1'b1;
    end
    if (|bus_ev[4:0]) begin
      r_d.bfa = bus_addr;
      r_d.cfs[15] = 1'b1;
    end
    if (vector_bus_err) begin
      r_d.hfs[`FEL_HF_VECT] = 1'b1;
    end
    if (escalate) begin
      r_d.hfs[`FEL_HF_ESC] = 1'b1;
    end
    if (hard) begin
      r_d.ist[0] = 1'b1;
    end
    if (cls != FEL_X_NONE && !escalate) begin
      r_d.ist[1] = 1'b1;
    end
    case (r_q.st)
      FEL_RUN: begin
        if (hard && (nmi_active || active_class == FEL_X_HARD)) begin
          r_d.st = FEL_LOCK;
          r_d.lock_nmi = hard_from_nmi;
          r_d.ist[2] = 1'b1;
        end else if (hard) begin
          r_d.take = FEL_X_HARD;
          r_d.tv = 1'b1;
        end else if (cls != FEL_X_NONE) begin
          r_d.take = cls;
          r_d.tv = 1'b1;
        end
      end
      FEL_LOCK: begin
        // Lockup blocks every handler entry
        if (debug_halt || (nmi_req && !r_q.lock_nmi)) begin
          r_d.st = FEL_RUN;
          r_d.lock_nmi = 1'b0;
        end
      end
      default: begin
        r_d.st = FEL_RUN;
      end
    endcase
    r_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == `FEL_REG_HFS) begin
        r_d.rdata = r_q.hfs;
      end else if (reg_addr == `FEL_REG_CFS) begin
        r_d.rdata = r_q.cfs;
      end else if (reg_addr == `FEL_REG_PFA) begin
        r_d.rdata = r_q.pfa;
      end else if (reg_addr == `FEL_REG_BFA) begin
        r_d.rdata = r_q.bfa;
      end else if (reg_addr == `FEL_REG_CTL) begin
        r_d.rdata = {29'h0000_0000, r_q.en};
      end else if (reg_addr == `FEL_REG_PRI) begin
        r_d.rdata = {8'h00, r_q.pri};
      end else if (reg_addr == `FEL_REG_IST) begin
        r_d.rdata = {29'h0000_0000, r_q.ist};
      end else if (reg_addr == `FEL_REG_IMSK) begin
        r_d.rdata = {29'h0000_0000, r_q.imsk};
      end else if (reg_addr == `FEL_REG_STAT) begin
        r_d.rdata = {30'h0000_0000, r_q.lock_nmi, r_q.st == FEL_LOCK};
      end
    end
    r_d.irq = |(r_d.ist & r_d.imsk);
    // Own flop so the lockup pin is not a decode of the state
    r_d.lock = r_d.st == FEL_LOCK;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign reg_rdata = r_q.rdata;
  assign take_exc = r_q.take;
  assign take_valid = r_q.tv;
  assign lockup = r_q.lock;
  assign irq = r_q.irq;
endmodule
`default_nettype wire

// ===== bench/fel_unit_props.sv
// Port checker of the fault unit
`timescale 1ns/10ps
`default_nettype none
module fel_unit_props
  import fel_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic vector_bus_err,
  input wire logic [2:0] active_class,
  input wire logic nmi_active,
  input wire logic nmi_req,
  input wire logic debug_halt,
  input wire logic [2:0] take_exc,
  input wire logic take_valid,
  input wire logic lockup
);
  logic org_q;
  // NMI state frozen while locked, so origin survives
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) org_q <= 1'b0;
    else if (!lockup) org_q <= nmi_active;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read slot");
  a_lock_no_take: assert property (lockup |-> !take_valid)
    else $error("handler entry in lockup");
  a_lock_enter: assert property (!lockup && vector_bus_err &&
    (nmi_active || active_class == FEL_X_HARD) |-> ##1 lockup)
    else $error("no lockup");
  a_lock_stay: assert property (lockup && !nmi_req && !debug_halt |=> lockup)
    else $error("lockup left early");
  a_halt_exit: assert property (lockup && debug_halt |=> !lockup)
    else $error("halt kept lockup");
  a_nmi_keep: assert property (lockup && org_q && nmi_req && !debug_halt |=> lockup)
    else $error("nmi released nmi lockup");
  a_nmi_exit: assert property (lockup && !org_q && nmi_req && !debug_halt |=> !lockup)
    else $error("nmi kept lockup");
  a_vect_take: assert property (vector_bus_err && !lockup && !nmi_active &&
    active_class != FEL_X_HARD |=> take_valid && take_exc == FEL_X_HARD)
    else $error("vector error not hard");
  c_lock_nmi: cover property (lockup && org_q && nmi_req);
  c_lock_hard: cover property (lockup && !org_q && nmi_req);
  c_hard_take: cover property (take_valid && take_exc == FEL_X_HARD);
endmodule
bind fel_unit fel_unit_props i_fel_unit_props (.*);
`default_nettype wire

// ===== bench/fel_core_model.sv
// Core-side model: one-cycle fault pulses and fault address
`timescale 1ns/10ps
`default_nettype none
module fel_core_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic [4:0] ev,
  input wire logic [31:0] a,
  output logic [4:0] prot_err,
  output logic [5:0] bus_err,
  output logic [5:0] usage_err,
  output logic no_execute_region,
  output logic vector_bus_err,
  output logic [31:0] prot_addr
);
  logic [31:0] last_q = '0;
  assign {vector_bus_err, no_execute_region, usage_err, bus_err, prot_err} =
    fire ? 19'h0_0001 << ev : '0;
  // Released address inverted so a stale capture shows up
  assign prot_addr = fire ? a : ~last_q;
  always_ff @(posedge clk) if (fire) last_q <= a;
endmodule
`default_nettype wire

// ===== bench/fel_unit_bench.sv
// Self-checking bench of the fault unit
`timescale 1ns/10ps
`default_nettype none
module fel_unit_bench
  import fel_pkg::*;
;
  logic clk = '0, resetn = '0, reg_wr = '0, reg_rd = '0, fire = '0, in_handler = '0;
  logic nmi_active = '0, nmi_req = '0, debug_halt = '0, take_valid, lockup, irq;
  logic no_execute_region, vector_bus_err;
  logic [2:0] active_class = '0, take_exc;
  logic [3:0] reg_addr = '0;
  logic [4:0] ev = '0, prot_err;
  logic [5:0] bus_err, usage_err;
  logic [7:0] cur_pri = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, a = '0, prot_addr, s = 32'hbc21_0e49, m = '0;
  wire logic [31:0] bus_addr = prot_addr;
  int n_errors = 0, check_count = 0;
  int bt[17] = '{0, 1, 3, 4, 5, 12, 11, 8, 13, 9, 10, 19, 16, 17, 18, 24, 25};
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  always #20 clk = ~clk;
  fel_core_model i_fel_core_model (.*);
  fel_unit i_fel_unit (.*);
  task automatic ck(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [31:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, ad};
    @(posedge clk) reg_rd <= 1'b0;
    #1 ck(reg_rdata, e);
  endtask
  task automatic fire_ev(input logic [4:0] v, input logic [2:0] x, input logic t);
    s = lfsr(s);
    @(posedge clk) {fire, ev, a} <= {1'b1, v, s};
    @(posedge clk) fire <= 1'b0;
    #1 ck(32'(take_valid), 32'(t));
    if (t) ck(32'(take_exc), 32'(x));
  endtask
  task automatic nmi();
    @(posedge clk) nmi_req <= 1'b1;
    @(posedge clk) nmi_req <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(4'hf, '0);
    rd(4'h4, '0);
    wr(4'h4, 32'h0000_0007);
    wr(4'h7, 32'h0000_0007);
    wr(4'h5, 32'h0040_4040);
    for (int v = 0; v < 17; v++) begin
      fire_ev(5'(v), v < 5 ? FEL_X_PROT : v < 11 ? FEL_X_BUS : FEL_X_USAGE, 1'b1);
      m |= 32'h0000_0001 << bt[v];
      m |= v < 5 ? 32'h0000_0080 : v < 10 ? 32'h0000_8000 : '0;
      rd(4'h1, m);
      if (v < 10) rd(v < 5 ? 4'h2 : 4'h3, s);
    end
    ck(32'(irq), 32'h0000_0001);
    wr(4'h1, '1);
    wr(4'h6, '1);
    rd(4'h6, '0);
    ck(32'(irq), '0);
    wr(4'h7, '0);
    fire_ev(5'h11, FEL_X_PROT, 1'b1);
    rd(4'h1, 32'h0000_0081);
    ck(32'(irq), '0);
    fire_ev(5'h12, FEL_X_HARD, 1'b1);
    rd(4'h0, 32'h0000_0002);
    wr(4'h4, 32'h0000_0003);
    fire_ev(5'h10, FEL_X_HARD, 1'b1);
    rd(4'h0, 32'h4000_0002);
    wr(4'h4, 32'h0000_0007);
    @(posedge clk) {in_handler, cur_pri, active_class} <= {1'b1, 8'h80, FEL_X_PROT};
    fire_ev(5'h10, FEL_X_USAGE, 1'b1);
    @(posedge clk) {cur_pri, active_class} <= {8'h40, FEL_X_USAGE};
    fire_ev(5'h0f, FEL_X_HARD, 1'b1);
    @(posedge clk) active_class <= FEL_X_BUS;
    fire_ev(5'h05, FEL_X_BUS, 1'b1);
    @(posedge clk) {in_handler, active_class, nmi_active} <= {1'b0, FEL_X_NONE, 1'b1};
    fire_ev(5'h12, FEL_X_HARD, 1'b0);
    nmi();
    rd(4'h8, 32'h0000_0003);
    @(posedge clk) debug_halt <= 1'b1;
    @(posedge clk) {debug_halt, nmi_active} <= '0;
    #1 ck(32'(lockup), '0);
    @(posedge clk) {in_handler, active_class} <= {1'b1, FEL_X_HARD};
    fire_ev(5'h12, FEL_X_HARD, 1'b0);
    fire_ev(5'h10, FEL_X_HARD, 1'b0);
    rd(4'h8, 32'h0000_0001);
    nmi();
    #1 ck(32'(lockup), '0);
    conclude();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
